// [hw/smsc_core.sv]
// Overview of operation
// [R01] master watches its select input for a collision with another master
// [R02] sampling and changing data alternate on successive serial clock edges
// [R03] phase 0 samples on first edge; phase 1 changes on first edge
// [R04] clock idles at polarity level; polarity and phase give four modes
// [R05] master output data line rests high between transfers
// [R06] in phase 0 the first bit is out before the first edge
// [R07] three-wire mode uses only the master-output line, half duplex
// [R08] first-direction 0: master sends first; 1: slave sends first
// [R09] three-wire slave output gets the same synchroniser delay as normal
// [R10] each queue is a holding register plus fifo, depth plus one
// [R11] tx not-full flag while a slot is free; software writes then
// [R12] a complete word goes to the rx queue and sets not-empty
// [R13] a word arriving with the rx queue full is dropped, overrun set
// [R14] selected slave with empty tx queue sends all ones, underrun set
// [R15] master never underruns; empty queue returns bus to idle clock
// [R16] master clock divides by (4-2*factor)*(modulus+1), times 16 option
// [R17] software leaves mode fields alone while the controller is enabled
// [R18] slave drives nothing until its select input goes active
// [R19] four-wire slave drives its first bit on select activation
// [R20] three-wire slave receives a word first, then drives its reply; the code returns to the first direction in idle, so every word goes that way
// [R21] slave reacts two cycles after an edge; master keeps clock slow
// [R22] slave accepts a clock level only after the modulus stable count
// [R23] select low in master mode aborts, flags error, disables
// [R24] word length 0 gives 32 bits, 3..15 give field plus one
// [R25] bit order control: cleared lsb first, set msb first
// [R26] master inserts configured idle clock cycles between words
// [R27] slave select and data inputs share the clock synchroniser stages
`timescale 1ns/10ps
`default_nettype none
`include "smsc_defines.svh"
module smsc_core (
  input wire logic mclk,
  input wire logic rst,
  input wire smsc_pkg::smsc_cfg_s cfg,
  input wire logic clear_events,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [31:0] tx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [31:0] rx_data,
  output smsc_pkg::smsc_evt_s events,
  output logic core_enabled,
  input wire logic select_in_pin,
  output logic slave_select_out,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe_n,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe_n,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe_n
);
  smsc_pkg::smsc_state_e state;
  logic [3:0] sync_q;
  logic sck_filt;
  logic sck_prev;
  logic sel_prev;
  logic [5:0] nbits;
  logic [5:0] bit_cnt;
  logic [31:0] sh_tx;
  logic [31:0] sh_rx;
  logic [9:0] div_cnt;
  logic [9:0] div_max;
  logic [5:0] gap_cnt;
  logic edge_idx;
  logic tq_valid;
  logic tq_pop;
  logic [31:0] tq_data;
  logic rq_push;
  logic rq_ready;
  logic [31:0] rq_data;
  logic [31:0] rx_word;
  logic word_done;
  logic underrun_now;
  logic collision;
  logic enabled;
  logic slv_active;
  logic half_out;
  logic shift_now;
  logic first_bit;
  logic next_bit;
  logic [31:0] next_rx;
  logic tick;
  logic sck_edge;
  logic lead_edge;
  logic sample_edge;
  logic rx_bit;
  logic out_bit;

  // queued words survive a disable so software may preload the queue
  smsc_fifo u_txq (
    .mclk(mclk), .rst(rst), .flush(1'b0),
    .in_valid(tx_valid), .in_ready(tx_ready), .in_data(tx_data),
    .out_valid(tq_valid), .out_ready(tq_pop), .out_data(tq_data)
  );
  smsc_fifo u_rxq (
    .mclk(mclk), .rst(rst), .flush(1'b0),
    .in_valid(rq_push), .in_ready(rq_ready), .in_data(rq_data),
    .out_valid(rx_valid), .out_ready(rx_ready), .out_data(rx_data)
  );
  smsc_sync u_sync (
    .mclk(mclk), .rst(rst), .filt_len(cfg.prescale_modulus),
    .raw_in({miso_in, mosi_in, select_in_pin, sck_in}),
    .sync_out(sync_q), .sck_filt(sck_filt)
  );

  // word length decode; illegal codes fall back to 32
  assign nbits = (cfg.word_length_field < `SMSC_LEN_MIN_LEGAL) ? 6'h20 :
                 6'({2'h0, cfg.word_length_field} + 6'h1); // [R24]

  // divider half-period: (4-2f)*(pm+1)*(16?) / 2 system cycles
  assign div_max = 10'((cfg.prescale_factor_sel ? 10'h1 : 10'h2) *
    (10'(cfg.prescale_modulus) + 10'h1) *
    (cfg.clock_div_sixteen ? 10'(`SMSC_CLOCK_DIV_SIXTEEN_MULT) : 10'h1) - 10'h1); // [R16]
  assign tick = (div_cnt == div_max);

  // collision while select is low in master mode and not ignored
  assign collision = enabled && cfg.master_mode_sel &&
    !cfg.ignore_select_in && !select_in_pin; // [R01] [R23]
  assign slv_active = enabled && !cfg.master_mode_sel && !sync_q[1]; // [R18]

  // slave edge of the filtered clock; master edge on divider tick
  assign sck_edge = cfg.master_mode_sel ? (state == smsc_pkg::SMSC_XFER && tick)
    : (slv_active && sck_filt != sck_prev); // [R21]
  // edge_idx 0 marks the first edge of each bit
  assign lead_edge = sck_edge && !edge_idx;
  assign sample_edge = cfg.cpha ? (sck_edge && edge_idx) : lead_edge; // [R03]
  // data changes on the non-sampling edge; phase 1 keeps bit 0 on edge 1
  assign shift_now = sck_edge && !sample_edge &&
    !(cfg.cpha && bit_cnt == 6'h0 && !edge_idx); // [R02]
  assign first_bit = cfg.msb_first ? tq_data[5'(nbits - 6'h1)] : tq_data[0];
  assign next_bit = cfg.msb_first ? sh_tx[30] : sh_tx[1];
  // the word is taken with its last bit included
  assign next_rx = cfg.msb_first ? {sh_rx[30:0], rx_bit} :
    {rx_bit, sh_rx[31:1]};
  assign rx_bit = cfg.master_mode_sel ?
    (cfg.three_wire ? mosi_in : miso_in) : sync_q[2]; // [R07]
  assign out_bit = cfg.msb_first ? sh_tx[31] : sh_tx[0]; // [R25]
  assign word_done = sample_edge && (bit_cnt == nbits - 6'h1);
  assign underrun_now = slv_active && !tq_valid && (state == smsc_pkg::SMSC_IDLE) &&
    (sck_filt != sck_prev); // [R14]
  assign tq_pop = enabled && tq_valid && (state == smsc_pkg::SMSC_IDLE) &&
    (cfg.master_mode_sel ? select_in_pin || cfg.ignore_select_in : slv_active);
  assign rx_word = cfg.msb_first ? next_rx & ((32'h1 << nbits) - 32'h1) :
    32'(next_rx >> (6'h20 - nbits));
  assign rq_data = rx_word;
  assign rq_push = word_done && rq_ready && !tw_drive_phase();

  // in three-wire mode only the receiving half stores a word
  function automatic logic tw_drive_phase();
    tw_drive_phase = cfg.three_wire && half_out;
  endfunction : tw_drive_phase

  // enable follows config; a collision clears it until multi_master_error is cleared
  always_ff @(posedge mclk)
  begin
    if (rst)
      enabled <= 1'b0;
    else if (!cfg.enable)
      enabled <= 1'b0;
    else if (collision)
      enabled <= 1'b0; // [R23]
    else if (!events.multi_master_error)
      enabled <= 1'b1;
  end

  // sequencing of words, bits and gaps
  always_ff @(posedge mclk)
  begin
    if (rst || !enabled || collision || (!cfg.master_mode_sel && !slv_active))
    begin
      state <= smsc_pkg::SMSC_IDLE;
      bit_cnt <= '0;
      edge_idx <= 1'b0;
      div_cnt <= '0;
      gap_cnt <= '0;
      sh_tx <= '1;
      sh_rx <= '0;
      half_out <= 1'b0;
    end
    else
    begin
      div_cnt <= (tick || state == smsc_pkg::SMSC_IDLE) ? 10'h0 : div_cnt + 10'h1;
      case (state)
        smsc_pkg::SMSC_IDLE:
        begin
          edge_idx <= 1'b0;
          bit_cnt <= '0;
          // three-wire master/slave roles pick the driving half
          half_out <= cfg.master_mode_sel ? !cfg.three_wire_first_direction
            : cfg.three_wire_first_direction; // [R08] [R20]
          if (tq_pop)
          begin
            sh_tx <= cfg.msb_first ? 32'(tq_data << (6'h20 - nbits)) : tq_data;
            state <= smsc_pkg::SMSC_XFER;
          end
          else if (underrun_now)
          begin
            sh_tx <= `SMSC_UNDERRUN_WORD; // [R14]
            state <= smsc_pkg::SMSC_XFER;
            edge_idx <= 1'b1;
            // the edge that starts an underrun may also carry bit 0
            if (sample_edge)
            begin
              sh_rx <= next_rx;
              bit_cnt <= 6'h1;
            end
          end
        end
        smsc_pkg::SMSC_XFER:
        begin
          if (sck_edge)
            edge_idx <= !edge_idx; // [R02]
          if (sample_edge)
            sh_rx <= next_rx;
          // change on the edge that is not the sampling one
          if (shift_now)
            sh_tx <= cfg.msb_first ? {sh_tx[30:0], 1'b1} : {1'b1, sh_tx[31:1]};
          if (sample_edge)
            bit_cnt <= bit_cnt + 6'h1;
          if (word_done)
          begin
            bit_cnt <= '0;
            if (cfg.three_wire && half_out == (cfg.master_mode_sel ?
                !cfg.three_wire_first_direction : cfg.three_wire_first_direction))
              half_out <= !half_out;
            gap_cnt <= '0;
            state <= smsc_pkg::SMSC_GAP;
          end
        end
        smsc_pkg::SMSC_GAP:
        begin
          // gap counted in half periods of the serial clock
          if (!cfg.master_mode_sel || cfg.word_gap_cycles == 5'h0)
            state <= smsc_pkg::SMSC_DONE;
          else if (tick)
          begin
            gap_cnt <= gap_cnt + 6'h1;
            if (gap_cnt == 6'({cfg.word_gap_cycles, 1'b0} - 6'h1))
              state <= smsc_pkg::SMSC_DONE; // [R26]
          end
        end
        smsc_pkg::SMSC_DONE:
          state <= smsc_pkg::SMSC_IDLE; // [R15]
        default:
          state <= smsc_pkg::SMSC_IDLE;
      endcase
    end
  end

  // edge history for slave clock and select
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      sck_prev <= 1'b0;
      sel_prev <= 1'b1;
    end
    else
    begin
      sck_prev <= slv_active ? sck_filt : cfg.cpol;
      sel_prev <= sync_q[1];
    end
  end

  // pin outputs straight from flops; enables low while driving
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      sck_out <= 1'b0;
      sck_oe_n <= 1'b1;
      mosi_out <= `SMSC_MOSI_IDLE;
      mosi_oe_n <= 1'b1;
      miso_out <= 1'b1;
      miso_oe_n <= 1'b1;
      slave_select_out <= 1'b1;
    end
    else if (enabled && cfg.master_mode_sel)
    begin
      // clock toggles only inside a word, idles at polarity level
      if (state != smsc_pkg::SMSC_XFER)
        sck_out <= cfg.cpol; // [R04] [R15]
      else if (tick)
        sck_out <= !sck_out;
      sck_oe_n <= 1'b0;
      // first bit leaves with the load, so it leads the first clock edge
      if (state == smsc_pkg::SMSC_IDLE && tq_pop)
        mosi_out <= first_bit; // [R06]
      else if (state != smsc_pkg::SMSC_XFER)
        mosi_out <= `SMSC_MOSI_IDLE; // [R05]
      else if (shift_now)
        mosi_out <= next_bit; // [R02]
      mosi_oe_n <= cfg.three_wire && !half_out && state == smsc_pkg::SMSC_XFER;
      miso_oe_n <= 1'b1; // [R07]
      slave_select_out <= (state == smsc_pkg::SMSC_IDLE && !tq_pop);
    end
    else if (slv_active)
    begin
      sck_oe_n <= 1'b1;
      // output follows synchronised edges, so delay matches both modes
      if (cfg.three_wire)
      begin
        mosi_out <= out_bit; // [R09]
        mosi_oe_n <= !half_out; // [R20]
        miso_oe_n <= 1'b1;
      end
      else
      begin
        miso_out <= out_bit; // [R19]
        miso_oe_n <= 1'b0;
        mosi_oe_n <= 1'b1;
      end
      slave_select_out <= 1'b1;
    end
    else
    begin
      sck_out <= cfg.cpol;
      sck_oe_n <= 1'b1;
      mosi_out <= `SMSC_MOSI_IDLE;
      mosi_oe_n <= 1'b1;
      miso_oe_n <= 1'b1; // [R18]
      slave_select_out <= 1'b1;
    end
  end

  // overrun, underrun and collision flags sticky; a new event wins over a clear in the same cycle
  always_ff @(posedge mclk)
  begin
    if (rst)
      events <= '0;
    else
    begin
      events.tx_not_full_flag <= tx_ready; // [R11]
      events.rx_not_empty_flag <= rx_valid || rq_push; // [R12]
      if (word_done && !rq_ready && !tw_drive_phase())
        events.rx_overrun_flag <= 1'b1; // [R13]
      else if (clear_events)
        events.rx_overrun_flag <= 1'b0;
      if (underrun_now && !cfg.master_mode_sel)
        events.tx_underrun_flag <= 1'b1;
      else if (clear_events)
        events.tx_underrun_flag <= 1'b0;
      if (collision)
        events.multi_master_error <= 1'b1;
      else if (clear_events)
        events.multi_master_error <= 1'b0;
    end
  end

  // visible enable state
  always_ff @(posedge mclk)
  begin
    if (rst)
      core_enabled <= 1'b0;
    else
      core_enabled <= enabled;
  end
endmodule : smsc_core
`default_nettype wire

// [hw/smsc_defines.svh]
`ifndef SMSC_DEFINES_SVH
`define SMSC_DEFINES_SVH
// word length field codes
`define SMSC_LEN_32 4'h0
`define SMSC_LEN_MIN_LEGAL 4'h3
// base divide factors of the master clock generator
`define SMSC_DIV_BASE 3'h4
`define SMSC_DIV_PRESCALE_FACTOR_SEL_STEP 3'h2
`define SMSC_CLOCK_DIV_SIXTEEN_MULT 5'h10
// slave clock synchroniser length in system cycles
`define SMSC_SYNC_STAGES 2
// queue geometry: fifo plus one holding register
`define SMSC_FIFO_DEPTH 32
`define SMSC_FIFO_AW 5
`define SMSC_WORD_W 32
// idle level of the master data line
`define SMSC_MOSI_IDLE 1'h1
`define SMSC_UNDERRUN_WORD 32'hffffffff
`endif

// [hw/smsc_pkg.sv]
package smsc_pkg;
  // static mode configuration
  typedef struct packed {
    logic enable;
    logic master_mode_sel;
    logic cpol;
    logic cpha;
    logic msb_first;
    logic three_wire;
    logic three_wire_first_direction;
    logic ignore_select_in;
    logic clock_div_sixteen;
    logic prescale_factor_sel;
    logic [3:0] prescale_modulus;
    logic [3:0] word_length_field;
    logic [4:0] word_gap_cycles;
  } smsc_cfg_s;

  // event flags
  typedef struct packed {
    logic tx_not_full_flag;
    logic rx_not_empty_flag;
    logic rx_overrun_flag;
    logic tx_underrun_flag;
    logic multi_master_error;
  } smsc_evt_s;

  typedef enum logic [3:0] {
    SMSC_IDLE = 4'h1,
    SMSC_XFER = 4'h2,
    SMSC_GAP = 4'h4,
    SMSC_DONE = 4'h8
  } smsc_state_e;
endpackage : smsc_pkg

// [hw/smsc_fifo.sv]
`timescale 1ns/10ps
`default_nettype none
`include "smsc_defines.svh"
// fifo plus holding register; capacity is depth plus one
module smsc_fifo #(
  parameter int WIDTH = `SMSC_WORD_W,
  parameter int DEPTH = `SMSC_FIFO_DEPTH,
  parameter int AW = `SMSC_FIFO_AW
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic hold_valid;
  logic fifo_pop;
  logic push;

  // holding register pulls from the array whenever it is free
  assign fifo_pop = (count != '0) && (!hold_valid || out_ready);
  assign push = in_valid && in_ready;
  assign in_ready = (count != (AW + 1)'(DEPTH)); // [R10]
  assign out_valid = hold_valid;

  // array pointers and occupancy
  always_ff @(posedge mclk)
  begin
    if (rst || flush)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
      begin
        mem[wr_ptr] <= in_data;
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (fifo_pop)
        rd_ptr <= rd_ptr + 1'b1;
      count <= count + (AW + 1)'(push) - (AW + 1)'(fifo_pop);
    end
  end

  // holding register stage
  always_ff @(posedge mclk)
  begin
    if (rst || flush)
    begin
      hold_valid <= 1'b0;
      out_data <= '0;
    end
    else if (fifo_pop)
    begin
      hold_valid <= 1'b1;
      out_data <= mem[rd_ptr];
    end
    else if (out_ready)
      hold_valid <= 1'b0;
  end
endmodule : smsc_fifo
`default_nettype wire

// [hw/smsc_sync.sv]
`timescale 1ns/10ps
`default_nettype none
`include "smsc_defines.svh"
// two-stage synchroniser plus stability filter on the serial clock
module smsc_sync (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] filt_len,
  input wire logic [3:0] raw_in,
  output logic [3:0] sync_out,
  output logic sck_filt
);
  logic [3:0] stage1;
  logic [3:0] filt_cnt;

  // same two stages for clock, select and data keep them aligned
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_sync
      always_ff @(posedge mclk)
      begin
        if (rst)
        begin
          stage1[gi] <= 1'b1;
          sync_out[gi] <= 1'b1;
        end
        else
        begin
          stage1[gi] <= raw_in[gi];
          sync_out[gi] <= stage1[gi]; // [R27]
        end
      end
    end
  endgenerate

  // clock level accepted once stable for filt_len plus one cycles
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      filt_cnt <= '0;
      sck_filt <= 1'b0;
    end
    else if (sync_out[0] == sck_filt)
      filt_cnt <= '0;
    else if (filt_cnt >= filt_len)
    begin
      sck_filt <= sync_out[0]; // [R22]
      filt_cnt <= '0;
    end
    else
      filt_cnt <= filt_cnt + 4'h1;
  end
endmodule : smsc_sync
`default_nettype wire

// [verif/smsc_core_assertions.sv]
`timescale 1ns/10ps
`default_nettype none
// watches the controller pins and flags from outside the core
module smsc_core_assertions (
  input wire logic mclk,
  input wire logic rst,
  input wire smsc_pkg::smsc_cfg_s cfg,
  input wire logic clear_events,
  input wire logic rx_valid,
  input wire logic tx_ready,
  input wire smsc_pkg::smsc_evt_s events,
  input wire logic core_enabled,
  input wire logic select_in_pin,
  input wire logic slave_select_out,
  input wire logic sck_out,
  input wire logic sck_oe_n,
  input wire logic mosi_out,
  input wire logic mosi_oe_n,
  input wire logic miso_oe_n
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // master with no word in flight for two cycles
  sequence s_bus_idle;
    cfg.master_mode_sel && slave_select_out && $past(slave_select_out, 2);
  endsequence
  // another master grabs the select line while we are enabled
  sequence s_collide;
    cfg.master_mode_sel && cfg.enable && !cfg.ignore_select_in &&
      core_enabled && $fell(select_in_pin);
  endsequence
  property p_sck_idle;
    s_bus_idle ##0 (!sck_oe_n && $stable(cfg.cpol)) |-> sck_out == cfg.cpol;
  endproperty
  a_sck_idle: assert property (p_sck_idle)
    else $error("clock not at idle level");
  property p_mosi_rest;
    s_bus_idle |-> mosi_out;
  endproperty
  a_mosi_rest: assert property (p_mosi_rest)
    else $error("data line not resting high");
  property p_collide;
    s_collide |-> ##[1:8] (events.multi_master_error && !core_enabled);
  endproperty
  a_collide: assert property (p_collide)
    else $error("collision not flagged");
  property p_ignore;
    cfg.ignore_select_in |-> !$rose(events.multi_master_error);
  endproperty
  a_ignore: assert property (p_ignore)
    else $error("collision flagged while ignored");
  property p_slave_quiet;
    !cfg.master_mode_sel && select_in_pin && $past(select_in_pin, 4)
      |-> miso_oe_n && mosi_oe_n && sck_oe_n;
  endproperty
  a_slave_quiet: assert property (p_slave_quiet)
    else $error("unselected slave drives a pin");
  property p_slave_drive;
    !cfg.master_mode_sel && cfg.enable && !cfg.three_wire &&
      $fell(select_in_pin) |-> ##[1:5] !miso_oe_n;
  endproperty
  a_slave_drive: assert property (p_slave_drive)
    else $error("selected slave not driving");
  property p_no_underrun;
    cfg.master_mode_sel && $past(cfg.master_mode_sel)
      |-> !$rose(events.tx_underrun_flag);
  endproperty
  a_no_underrun: assert property (p_no_underrun)
    else $error("underrun in master mode");
  property p_rx_flag;
    $rose(rx_valid) |-> ##[0:2] events.rx_not_empty_flag;
  endproperty
  a_rx_flag: assert property (p_rx_flag)
    else $error("not-empty flag missing");
  property p_tx_flag;
    $fell(tx_ready) |-> ##[0:2] !events.tx_not_full_flag;
  endproperty
  a_tx_flag: assert property (p_tx_flag)
    else $error("not-full flag stays with full queue");
  property p_ovr_sticky;
    events.rx_overrun_flag && !clear_events |=> events.rx_overrun_flag;
  endproperty
  a_ovr_sticky: assert property (p_ovr_sticky)
    else $error("overrun flag lost");
endmodule : smsc_core_assertions
`default_nettype wire

// [verif/smsc_slave_model.sv]
`timescale 1ns/10ps
`default_nettype none
// behavioural spi slave facing the controller in master mode
module smsc_slave_model #(
  parameter logic [31:0] REPLY = 32'h0
) (
  input wire logic sck,
  input wire logic mosi,
  input wire logic sel_n,
  input wire logic cpol,
  input wire logic cpha,
  input wire logic msb_first,
  input wire logic [5:0] nbits,
  output logic miso,
  output logic [31:0] rx_word,
  output int n_words
);
  logic q = 1'b1;
  logic [31:0] sh = 32'h0;
  int k = 0;
  function automatic logic pick(input int i);
    pick = msb_first ? REPLY[nbits - 6'h1 - 6'(i)] : REPLY[i];
  endfunction : pick
  initial n_words = 0;
  initial rx_word = 32'h0;
  // selection restarts the word with its first bit already out
  always @(negedge sel_n)
  begin
    k = 0;
    sh = 32'h0;
    q = pick(0);
  end
  // leading edge leaves the idle level; phase picks sample or change
  always @(sck)
  begin
    if (!sel_n && ((sck != cpol) ^ cpha))
    begin
      sh = msb_first ? {sh[30:0], mosi} : sh | ({31'h0, mosi} << k);
      k++;
      if (k == int'(nbits))
      begin
        rx_word = sh;
        n_words++;
        k = 0;
        sh = 32'h0;
      end
    end
    else if (!sel_n)
      q = pick(k);
  end
  // a released line shows the inverse, so a stale copy never passes
  assign miso = sel_n ? ~q : q;
endmodule : smsc_slave_model
`default_nettype wire

// [verif/spi_master_slave_controller_bench.sv]
`timescale 1ns/10ps
`default_nettype none
module spi_master_slave_controller_bench;
  localparam logic [31:0] REPLY = 32'h6b2d_e1c7;
  localparam logic [31:0] WORD = 32'hc4f1_9a37;
  localparam logic [3:0] LENS [5] = '{4'h7, 4'h3, 4'hf, 4'h0, 4'h7};
  smsc_pkg::smsc_cfg_s cfg = '0;
  smsc_pkg::smsc_evt_s events;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic clear_events = 1'b0;
  logic tx_valid = 1'b0;
  logic rx_ready = 1'b0;
  logic sel_in = 1'b1;
  logic sck_d = 1'b0;
  logic mosi_d = 1'b1;
  logic [31:0] tx_data = 32'h0;
  logic [31:0] rx_data, m_rx;
  logic [7:0] got;
  logic [5:0] nbits;
  logic tx_ready, rx_valid, core_enabled, ssel_out, m_miso;
  logic sck_o, sck_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n;
  logic sck_w, mosi_w, miso_w;
  int n_words;
  int n_fail = 0;
  int compares = 0;
  assign nbits = cfg.word_length_field == 4'h0 ? 6'h20 :
    {2'h0, cfg.word_length_field} + 6'h1;
  // wire levels: an enabled driver wins over the bench side
  assign sck_w = sck_oe_n ? sck_d : sck_o;
  assign mosi_w = mosi_oe_n ? mosi_d : mosi_o;
  assign miso_w = miso_oe_n ? m_miso : miso_o;
  initial forever #20 mclk = ~mclk;
  smsc_core u_smsc_core (.mclk(mclk), .rst(rst), .cfg(cfg),
    .clear_events(clear_events), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_data(tx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_data(rx_data), .events(events), .core_enabled(core_enabled),
    .select_in_pin(sel_in), .slave_select_out(ssel_out), .sck_in(sck_w),
    .sck_out(sck_o), .sck_oe_n(sck_oe_n), .mosi_in(mosi_w),
    .mosi_out(mosi_o), .mosi_oe_n(mosi_oe_n), .miso_in(miso_w),
    .miso_out(miso_o), .miso_oe_n(miso_oe_n));
  smsc_slave_model #(.REPLY(REPLY)) u_smsc_slave_model (.sck(sck_w),
    .mosi(mosi_w), .sel_n(ssel_out), .cpol(cfg.cpol), .cpha(cfg.cpha),
    .msb_first(cfg.msb_first), .nbits(nbits), .miso(m_miso),
    .rx_word(m_rx), .n_words(n_words));
  function automatic logic [31:0] mask(input logic [5:0] n);
    mask = n == 6'h20 ? 32'hffffffff : (32'h1 << n) - 32'h1;
  endfunction : mask
  task automatic chk(input logic [31:0] g, input logic [31:0] e,
    input string what);
    compares++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] %0t %s: got %h exp %h", $time, what, g, e);
    end
  endtask : chk
  task automatic push(input logic [31:0] d);
    @(posedge mclk);
    tx_valid <= 1'b1;
    tx_data <= d;
    @(posedge mclk);
    chk(tx_ready, 32'h1, "tx taken");
    tx_valid <= 1'b0;
  endtask : push
  // one edge first, so a word just taken is not seen again
  task automatic pop(input logic [31:0] e);
    @(posedge mclk);
    for (int i = 0; i < 300 && rx_valid !== 1'b1; i++) @(posedge mclk);
    rx_ready <= 1'b1;
    chk(rx_data, e, "rx word");
    @(posedge mclk);
    rx_ready <= 1'b0;
  endtask : pop
  task automatic wait_words(input int n);
    for (int i = 0; i < 4000 && n_words < n; i++) @(posedge mclk);
    chk(32'(n_words), 32'(n), "words at slave");
  endtask : wait_words
  // mode fields change only while the core is disabled
  task automatic reenable();
    @(posedge mclk);
    cfg.enable <= 1'b1;
  endtask : reenable
  task automatic tally_and_finish();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    repeat (30000) @(posedge mclk);
    n_fail++;
    $display("[ERR] %0t watchdog expired", $time);
    tally_and_finish();
  end
  initial
  begin
    @(posedge mclk);
    cfg.master_mode_sel <= 1'b1;
    cfg.prescale_factor_sel <= 1'b1;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    // four bus modes, both bit orders, short, long and full words
    for (int i = 0; i < 5; i++)
    begin
      @(posedge mclk);
      cfg.enable <= 1'b0;
      repeat (2) @(posedge mclk);
      cfg.cpol <= i[1];
      cfg.cpha <= i[0];
      cfg.msb_first <= i[0] ^ i[1];
      cfg.word_length_field <= LENS[i];
      reenable();
      push(WORD >> i);
      wait_words(i + 1);
      chk(m_rx, (WORD >> i) & mask(nbits), "slave word");
      pop(REPLY & mask(nbits));
    end
    // fill the disabled queue, then overrun the receive side
    @(posedge mclk);
    cfg.enable <= 1'b0;
    for (int i = 0; i < 33; i++) push(32'(i));
    repeat (2) @(posedge mclk);
    chk(tx_ready, 32'h0, "tx full");
    chk(events.tx_not_full_flag, 32'h0, "not full flag");
    reenable();
    wait_words(38);
    push(32'h5a);
    wait_words(39);
    repeat (4) @(posedge mclk);
    chk(events.rx_overrun_flag, 32'h1, "overrun");
    for (int i = 0; i < 33; i++) pop(REPLY & 32'hff);
    repeat (3) @(posedge mclk);
    chk(events.rx_not_empty_flag, 32'h0, "rx empty");
    clear_events <= 1'b1;
    @(posedge mclk);
    clear_events <= 1'b0;
    cfg.enable <= 1'b0;
    cfg.ignore_select_in <= 1'b1;
    reenable();
    sel_in <= 1'b0;
    repeat (10) @(posedge mclk);
    chk(events.rx_overrun_flag, 32'h0, "overrun cleared");
    chk(events.multi_master_error, 32'h0, "select ignored");
    sel_in <= 1'b1;
    cfg.enable <= 1'b0;
    cfg.ignore_select_in <= 1'b0;
    reenable();
    // another master takes the bus mid-word
    push(32'ha5);
    repeat (3) @(posedge mclk);
    sel_in <= 1'b0;
    repeat (10) @(posedge mclk);
    chk(events.multi_master_error, 32'h1, "collision");
    chk(core_enabled, 32'h0, "core disabled");
    sel_in <= 1'b1;
    rst <= 1'b1;
    cfg.master_mode_sel <= 1'b0;
    cfg.msb_first <= 1'b1;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    repeat (8) @(posedge mclk);
    // slave with empty queue, bench clocks a byte in mode 0
    chk(miso_oe_n, 32'h1, "slave quiet");
    sel_in <= 1'b0;
    repeat (6) @(posedge mclk);
    chk(miso_oe_n, 32'h0, "slave drives");
    for (int i = 7; i >= 0; i--)
    begin
      mosi_d <= 1'(8'h3c >> i);
      repeat (6) @(posedge mclk);
      got[i] = miso_w;
      sck_d <= 1'b1;
      repeat (6) @(posedge mclk);
      sck_d <= 1'b0;
    end
    repeat (6) @(posedge mclk);
    sel_in <= 1'b1;
    chk({24'h0, got}, 32'hff, "underrun ones");
    chk(events.tx_underrun_flag, 32'h1, "underrun flag");
    pop(32'h3c);
    tally_and_finish();
  end
endmodule : spi_master_slave_controller_bench
bind smsc_core smsc_core_assertions u_smsc_core_assertions (.mclk(mclk),
  .rst(rst), .cfg(cfg), .clear_events(clear_events), .rx_valid(rx_valid),
  .tx_ready(tx_ready), .events(events), .core_enabled(core_enabled),
  .select_in_pin(select_in_pin), .slave_select_out(slave_select_out),
  .sck_out(sck_out), .sck_oe_n(sck_oe_n), .mosi_out(mosi_out),
  .mosi_oe_n(mosi_oe_n), .miso_oe_n(miso_oe_n));
`default_nettype wire
